// [core/bst_defines.vh]
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH
// Instruction register
`define BSC_IR_LEN 10
`define BSC_OP_EXTEST 10'h000
`define BSC_OP_SAMPLE 10'h005
`define BSC_OP_IDCODE 10'h006
`define BSC_OP_USERCODE 10'h007
`define BSC_OP_CFG_START 10'h002
`define BSC_OP_CFG_DATA 10'h003
`define BSC_OP_CFG_DONE 10'h004
`define BSC_OP_BYPASS 10'h3ff
`define BSC_IR_CAPTURE 10'h001
// Identification word fields
`define BSC_ID_LSB_POS 0
`define BSC_ID_MAKER_POS 1
`define BSC_ID_PART_POS 12
`define BSC_ID_VER_POS 28
// Signature register split
`define BSC_UC_LEN 32
`define BSC_UC_USER_BITS 7
// Reset values
`define BSC_RST_ONE 1'b1
`endif

// [core/bst_sync.v]
`timescale 1ns/10ps
`include "bst_defines.vh"
module bsc_sync #(
    parameter WIDTH = 4
) (
    input wire mclk,
    input wire sys_rst,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
reg [WIDTH-1:0] stage1_ff;
reg [WIDTH-1:0] stage2_ff;
// Resets to ones so idle pins look pulled up
always @(posedge mclk) begin
    if (sys_rst) begin
        stage1_ff <= {WIDTH{`BSC_RST_ONE}};
        stage2_ff <= {WIDTH{`BSC_RST_ONE}};
    end else begin
        stage1_ff <= din;
        stage2_ff <= stage1_ff;
    end
end
assign dout = stage2_ff;
endmodule // bsc_sync

// [core/bst_tap.v]
`timescale 1ns/10ps
`include "bst_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - The port runs the standard sixteen-state TAP machine with capture, shift and update.
// - Boundary-scan test is refused while configuration is in progress.
// - Configuration data can be shifted in through the scan pins.
// - Sample/preload captures pins while the core runs and holds shifted data for later drive.
// - Extest drives outputs from the update latches and captures the input pins.
// - Bypass puts a single-bit register between data in and data out.
// - Usercode shifts the 32-bit user signature out on data out.
// - Idcode shifts the 32-bit identification word out on data out.
// - Device-specific instructions start, feed and finish configuration.
// - The instruction register is ten bits long.
// - The signature has seven user bits and twenty-five fixed bits.
// - The identification word is version, part, maker code and a one in the lsb.
// - Undriven scan inputs read as one.
module bsc_tap #(
    parameter BSR_LEN = 16,
    parameter [3:0] ID_VERSION = 4'h1,
    parameter [15:0] ID_PART = 16'h1234, // Arbitrary value
    parameter [10:0] ID_MAKER = 11'h055, // Arbitrary value
    parameter [24:0] UC_FIXED = 25'h000_0000
) (
    input wire mclk,
    input wire sys_rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trstN,
    output reg tdo,
    output reg tdoOe,
    input wire [BSR_LEN-1:0] pinIn,
    input wire [BSR_LEN-1:0] coreOut,
    output reg [BSR_LEN-1:0] pinOut,
    input wire [6:0] userSig,
    output reg cfgBusy,
    output reg cfgDone,
    output reg cfgWordValid,
    output reg [31:0] cfgWord
);
// TAP controller states
localparam [3:0] S_RESET = 4'h0;
localparam [3:0] S_IDLE = 4'h1;
localparam [3:0] S_SEL_DR = 4'h2;
localparam [3:0] S_CAP_DR = 4'h3;
localparam [3:0] S_SH_DR = 4'h4;
localparam [3:0] S_EX1_DR = 4'h5;
localparam [3:0] S_PAU_DR = 4'h6;
localparam [3:0] S_EX2_DR = 4'h7;
localparam [3:0] S_UPD_DR = 4'h8;
localparam [3:0] S_SEL_IR = 4'h9;
localparam [3:0] S_CAP_IR = 4'ha;
localparam [3:0] S_SH_IR = 4'hb;
localparam [3:0] S_EX1_IR = 4'hc;
localparam [3:0] S_PAU_IR = 4'hd;
localparam [3:0] S_EX2_IR = 4'he;
localparam [3:0] S_UPD_IR = 4'hf;
wire [3:0] syncIn;
wire [BSR_LEN-1:0] pinInS;
reg tckDly_ff;
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [`BSC_IR_LEN-1:0] irShift_ff;
reg [`BSC_IR_LEN-1:0] ir_ff;
reg bypass_ff;
reg [31:0] dr32_ff;
reg [BSR_LEN-1:0] bsr_ff;
reg [BSR_LEN-1:0] bsrUpd_ff;
reg [4:0] cfgCnt_ff;
wire tckRise;
wire tckFall;
wire tmsS;
wire tdiS;
wire trstS;
wire [31:0] idWord;
wire [31:0] ucWord;
wire [2:0] sel;
// Pull-ups are modelled by the synchroniser reset value, trstN undriven reads high
bsc_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din({tck, tms, tdi, trstN}),
    .dout(syncIn)
);
// Board pins are asynchronous to mclk as well
bsc_sync #(.WIDTH(BSR_LEN)) u_pinSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(pinIn),
    .dout(pinInS)
);
assign tmsS = syncIn[2];
assign tdiS = syncIn[1];
assign trstS = syncIn[0];
assign tckRise = syncIn[3] & ~tckDly_ff;
assign tckFall = ~syncIn[3] & tckDly_ff;
assign idWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
assign ucWord = {UC_FIXED, userSig};
////////////////////////////////////////////////////////////////////////////////
// Instruction decode: 0 bypass, 1 boundary, 2 id, 3 user, 4 config data
function [2:0] dec_sel;
    input [`BSC_IR_LEN-1:0] op;
    input busy;
    begin
        case (op)
            `BSC_OP_EXTEST: dec_sel = busy ? 3'h0 : 3'h1;
            `BSC_OP_SAMPLE: dec_sel = busy ? 3'h0 : 3'h1;
            `BSC_OP_IDCODE: dec_sel = 3'h2;
            `BSC_OP_USERCODE: dec_sel = 3'h3;
            `BSC_OP_CFG_DATA: dec_sel = 3'h4;
            `BSC_OP_BYPASS: dec_sel = 3'h0;
            default: dec_sel = 3'h0;
        endcase
    end
endfunction
assign sel = dec_sel(ir_ff, cfgBusy);
////////////////////////////////////////////////////////////////////////////////
// TAP state machine
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        S_RESET: nxt_state = tmsS ? S_RESET : S_IDLE;
        S_IDLE: nxt_state = tmsS ? S_SEL_DR : S_IDLE;
        S_SEL_DR: nxt_state = tmsS ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: nxt_state = tmsS ? S_EX1_DR : S_SH_DR;
        S_SH_DR: nxt_state = tmsS ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: nxt_state = tmsS ? S_UPD_DR : S_PAU_DR;
        S_PAU_DR: nxt_state = tmsS ? S_EX2_DR : S_PAU_DR;
        S_EX2_DR: nxt_state = tmsS ? S_UPD_DR : S_SH_DR;
        S_UPD_DR: nxt_state = tmsS ? S_SEL_DR : S_IDLE;
        S_SEL_IR: nxt_state = tmsS ? S_RESET : S_CAP_IR;
        S_CAP_IR: nxt_state = tmsS ? S_EX1_IR : S_SH_IR;
        S_SH_IR: nxt_state = tmsS ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: nxt_state = tmsS ? S_UPD_IR : S_PAU_IR;
        S_PAU_IR: nxt_state = tmsS ? S_EX2_IR : S_PAU_IR;
        S_EX2_IR: nxt_state = tmsS ? S_UPD_IR : S_SH_IR;
        S_UPD_IR: nxt_state = tmsS ? S_SEL_DR : S_IDLE;
        default: nxt_state = S_RESET;
    endcase
end
always @(posedge mclk) begin
    if (sys_rst) begin
        tckDly_ff <= 1'b1;
        state_ff <= S_RESET;
    end else begin
        tckDly_ff <= syncIn[3];
        if (!trstS) begin
            state_ff <= S_RESET;
        end else if (tckRise) begin
            state_ff <= nxt_state;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// Capture and shift on the rising edge, update on the falling edge
always @(posedge mclk) begin
    if (sys_rst || !trstS) begin
        irShift_ff <= `BSC_IR_CAPTURE;
        ir_ff <= `BSC_OP_IDCODE;
        bypass_ff <= 1'b0;
        dr32_ff <= 32'h0000_0000;
        bsr_ff <= {BSR_LEN{1'b0}};
        bsrUpd_ff <= {BSR_LEN{1'b0}};
        cfgBusy <= 1'b0;
        cfgDone <= 1'b0;
        cfgWordValid <= 1'b0;
        cfgWord <= 32'h0000_0000;
        cfgCnt_ff <= 5'h00;
        tdo <= 1'b0;
        tdoOe <= 1'b0;
        pinOut <= {BSR_LEN{1'b0}};
    end else begin
        cfgWordValid <= 1'b0;
        if (tckRise) begin
            case (state_ff)
                S_RESET: ir_ff <= `BSC_OP_IDCODE;
                S_CAP_IR: irShift_ff <= `BSC_IR_CAPTURE;
                S_SH_IR: irShift_ff <= {tdiS, irShift_ff[`BSC_IR_LEN-1:1]};
                S_CAP_DR: begin
                    bypass_ff <= 1'b0;
                    cfgCnt_ff <= 5'h00;
                    if (sel == 3'h1) begin
                        bsr_ff <= pinInS;
                    end
                    if (sel == 3'h2) begin
                        dr32_ff <= idWord;
                    end
                    if (sel == 3'h3) begin
                        dr32_ff <= ucWord;
                    end
                end
                S_SH_DR: begin
                    case (sel)
                        3'h1: bsr_ff <= {tdiS, bsr_ff[BSR_LEN-1:1]};
                        3'h2, 3'h3: dr32_ff <= {tdiS, dr32_ff[31:1]};
                        3'h4: begin
                            // Config words assemble lsb first, one pulse per 32 bits
                            dr32_ff <= {tdiS, dr32_ff[31:1]};
                            cfgCnt_ff <= cfgCnt_ff + 5'h01;
                            if (cfgCnt_ff == 5'h1f) begin
                                cfgWord <= {tdiS, dr32_ff[31:1]};
                                cfgWordValid <= 1'b1;
                            end
                        end
                        default: bypass_ff <= tdiS;
                    endcase
                end
                default: ;
            endcase
        end
        if (tckFall) begin
            tdoOe <= (state_ff == S_SH_DR) || (state_ff == S_SH_IR);
            if (state_ff == S_SH_IR) begin
                tdo <= irShift_ff[0];
            end else begin
                case (sel)
                    3'h1: tdo <= bsr_ff[0];
                    3'h2, 3'h3, 3'h4: tdo <= dr32_ff[0];
                    default: tdo <= bypass_ff;
                endcase
            end
            if (state_ff == S_UPD_IR) begin
                ir_ff <= irShift_ff;
                // Config instructions bracket the load
                if (irShift_ff == `BSC_OP_CFG_START) begin
                    cfgBusy <= 1'b1;
                    cfgDone <= 1'b0;
                end
                if (irShift_ff == `BSC_OP_CFG_DONE && cfgBusy) begin
                    cfgBusy <= 1'b0;
                    cfgDone <= 1'b1;
                end
            end
            if (state_ff == S_UPD_DR && sel == 3'h1) begin
                bsrUpd_ff <= bsr_ff;
            end
        end
        // Extest outside configuration drives from latches; otherwise the core keeps the pins
        if (ir_ff == `BSC_OP_EXTEST && !cfgBusy) begin
            pinOut <= bsrUpd_ff;
        end else begin
            pinOut <= coreOut;
        end
    end
end
endmodule // bsc_tap

// [tb/bst_scan_ctl.sv]
`timescale 1ns/10ps
module bsc_scan_ctl (
    input wire logic mclk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // Link clock stands low between frames; idle lines sit at pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 200 ns link clock, called on a falling mclk edge with the link clock low:
    // four mclk low, four high; tdo read late in the high phase, where it is settled
    task automatic cyc(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge mclk);
        tck = 1'b1;
        repeat (4) @(negedge mclk);
        q = tdo;
        tck = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // From idle: select, capture, n shift bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] di,
                        output logic [31:0] dq);
        logic q;
        dq = 32'h0000_0000;
        cyc(1'b1, 1'b1, q);
        if (ir) cyc(1'b1, 1'b1, q);
        cyc(1'b0, 1'b1, q);
        cyc(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, di[i], q);
            dq[i] = q;
        end
        cyc(1'b1, 1'b1, q);
        cyc(1'b0, 1'b1, q);
    endtask
    // Leaves test-logic-reset for run-test/idle, where every scan starts
    task automatic idle;
        logic q;
        cyc(1'b0, 1'b1, q);
    endtask
endmodule // bsc_scan_ctl

// [tb/bst_tap_monitor.sv]
`timescale 1ns/10ps
module bsc_tap_monitor #(
    parameter BSR_LEN = 16
) (
    input wire mclk,
    input wire sys_rst,
    input wire tck,
    input wire trstN,
    input wire tdo,
    input wire tdoOe,
    input wire [BSR_LEN-1:0] coreOut,
    input wire [BSR_LEN-1:0] pinOut,
    input wire cfgBusy,
    input wire cfgDone,
    input wire cfgWordValid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    AST_RST_OUTS: assert property ($fell(sys_rst) |-> !cfgBusy && !cfgDone && !tdoOe)
        else $error("outputs not clear after reset");
    AST_TRST_CLEARS: assert property ($fell(trstN) |-> ##[1:6] !cfgBusy && !tdoOe)
        else $error("scan reset ignored");
    // Synchroniser delay keeps both edges at least two cycles behind the pin
    AST_TDO_ON_FALL: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("tdo moved outside low phase");
    // The enable follows the falling link edge, like tdo itself
    AST_OE_ON_FALL: assert property ($rose(tdoOe) |-> !$past(tck, 2))
        else $error("tdo enable rose outside low phase");
    AST_PINS_IN_CFG: assert property ($past(cfgBusy) && cfgBusy |-> pinOut == $past(coreOut))
        else $error("pins not core driven during config");
    AST_WORD_PULSE: assert property (cfgWordValid |=> !cfgWordValid [*8])
        else $error("word strobe too long");
    AST_WORD_IN_CFG: assert property (cfgWordValid |-> cfgBusy)
        else $error("word outside config");
    AST_DONE_AFTER: assert property ($rose(cfgDone) |-> $past(cfgBusy))
        else $error("done without config");
    COV_WORD: cover property (cfgWordValid);
    COV_DONE: cover property ($rose(cfgDone));
    COV_SHIFT: cover property ($rose(tdoOe));
endmodule // bsc_tap_monitor
bind bsc_tap bsc_tap_monitor #(.BSR_LEN(BSR_LEN)) bsc_tap_monitor_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tck(tck),
    .trstN(trstN),
    .tdo(tdo),
    .tdoOe(tdoOe),
    .coreOut(coreOut),
    .pinOut(pinOut),
    .cfgBusy(cfgBusy),
    .cfgDone(cfgDone),
    .cfgWordValid(cfgWordValid)
);

// [tb/bst_tap_tb.sv]
`timescale 1ns/10ps
module bsc_tap_tb;
    localparam logic [31:0] ID_WORD = {4'h1, 16'h1234, 11'h055, 1'b1};
    logic mclk, sysRst, trstN, tck, tms, tdi, tdo, tdoOe;
    logic [15:0] pinIn, coreOut, pinOut;
    logic [6:0] userSig;
    logic cfgBusy, cfgDone, cfgWordValid;
    logic [31:0] cfgWord, dq;
    logic [31:0] cfgSeen = 32'h0000_0000;
    int oeCnt = 0;
    int err_total = 0;
    int checks_done = 0;
    bsc_tap #(.BSR_LEN(16), .ID_VERSION(4'h1), .ID_PART(16'h1234), .ID_MAKER(11'h055))
        bsc_tap_i (.mclk(mclk), .sys_rst(sysRst), .tck(tck), .tms(tms), .tdi(tdi),
        .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .pinIn(pinIn), .coreOut(coreOut),
        .pinOut(pinOut), .userSig(userSig), .cfgBusy(cfgBusy), .cfgDone(cfgDone),
        .cfgWordValid(cfgWordValid), .cfgWord(cfgWord));
    bsc_scan_ctl bsc_scan_ctl_i (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (cfgWordValid) cfgSeen <= cfgWord;
    always @(posedge mclk) if (tdoOe) oeCnt <= oeCnt + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ir(input logic [9:0] op);
        bsc_scan_ctl_i.scan(1'b1, 10, {22'h0, op}, dq);
        chk("ir capture", 32'h0000_0001, dq);
    endtask
    task automatic dr(input int n, input logic [31:0] di);
        bsc_scan_ctl_i.scan(1'b0, n, di, dq);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_ids;
        int oe0;
        oe0 = oeCnt;
        dr(32, 0);
        chk("idcode", ID_WORD, dq);
        // Enable stands for 32 link periods of eight mclk each
        chk("oe cycles", 32'h0000_0100, 32'(oeCnt - oe0));
        chk("oe idle", 32'h0, 32'(tdoOe));
        ir(10'h007);
        dr(32, 0);
        chk("usercode", {25'h0, userSig}, dq);
        $display("id test done");
    endtask
    // Unassigned code must behave exactly like all-ones
    task automatic t_bypass;
        for (int k = 0; k < 2; k++) begin
            ir(k ? 10'h155 : 10'h3FF);
            dr(8, 32'h0000_00B7);
            chk("bypass", 32'h0000_006E, dq);
            chk("bypass pins", 32'(coreOut), 32'(pinOut));
        end
        $display("bypass test done");
    endtask
    task automatic t_pins;
        ir(10'h005);
        dr(16, 32'h0000_3C96);
        chk("sample", 32'(pinIn), dq);
        chk("sample pins", 32'(coreOut), 32'(pinOut));
        ir(10'h000);
        chk("preload pins", 32'h0000_3C96, 32'(pinOut));
        pinIn = 16'h5A0F;
        dr(16, 32'h0000_C3F0);
        chk("extest capture", 32'h0000_5A0F, dq);
        chk("extest pins", 32'h0000_C3F0, 32'(pinOut));
        $display("pin test done");
    endtask
    task automatic t_config;
        ir(10'h002);
        chk("busy", 32'h1, 32'(cfgBusy));
        ir(10'h003);
        dr(32, 32'hDEAD_BEEF);
        chk("config word", 32'hDEAD_BEEF, cfgSeen);
        ir(10'h000);
        dr(8, 32'h0000_00B7);
        chk("extest in config", 32'h0000_006E, dq);
        chk("pins in config", 32'(coreOut), 32'(pinOut));
        ir(10'h004);
        chk("done", 32'h1, 32'(cfgDone));
        trstN = 1'b0;
        repeat (6) @(negedge mclk);
        trstN = 1'b1;
        repeat (4) @(negedge mclk);
        chk("done after scan reset", 32'h0, 32'(cfgDone));
        bsc_scan_ctl_i.idle();
        dr(32, 0);
        chk("idcode after scan reset", ID_WORD, dq);
        $display("config test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sysRst = 1'b1;
        trstN = 1'b1;
        pinIn = 16'hA5C3;
        coreOut = 16'h1E2D;
        userSig = 7'h5A;
        repeat (8) @(negedge mclk);
        sysRst = 1'b0;
        repeat (4) @(negedge mclk);
        bsc_scan_ctl_i.idle();
        t_ids();
        t_bypass();
        t_pins();
        t_config();
        test_done();
    end
    // Whole run is well under 1 ms of link traffic
    initial begin
        #2_000_000;
        err_total++;
        test_done();
    end
endmodule // bsc_tap_tb
